/* File: aiex_pkg.sv */
package aiex_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] AIEX_OFF_CTRL       = 8'h00;
	localparam logic [7:0] AIEX_OFF_INSTR      = 8'h04;
	localparam logic [7:0] AIEX_OFF_WREG       = 8'h08;
	localparam logic [7:0] AIEX_OFF_FLAGS      = 8'h0C;
	localparam logic [7:0] AIEX_OFF_BANK       = 8'h10;
	localparam logic [7:0] AIEX_OFF_INDEX_BASE = 8'h14;
	localparam logic [7:0] AIEX_OFF_MEM_ADDR   = 8'h18;
	localparam logic [7:0] AIEX_OFF_MEM_DATA   = 8'h1C;
	localparam logic [7:0] AIEX_OFF_EXEC_STAT  = 8'h20;

	// opcode fields
	localparam logic [7:0] AIEX_OPC_LIT      = 8'h0F;
	localparam logic [5:0] AIEX_OPC_FILE     = 6'h09;
	localparam int         AIEX_POS_DEST     = 9;
	localparam int         AIEX_POS_BANKSEL  = 8;

	// data address space
	localparam int         AIEX_ADDR_W       = 12;
	localparam int         AIEX_MEM_DEPTH    = 4096;
	localparam logic [7:0] AIEX_ILO_MAX      = 8'h5F;
	localparam logic [7:0] AIEX_ACC_SPLIT    = 8'h60;
	localparam logic [3:0] AIEX_ACC_LO_BANK  = 4'h0;
	localparam logic [3:0] AIEX_ACC_HI_BANK  = 4'hF;

	// flag bit positions
	localparam int AIEX_FLG_C  = 0;
	localparam int AIEX_FLG_DC = 1;
	localparam int AIEX_FLG_Z  = 2;
	localparam int AIEX_FLG_OV = 3;
	localparam int AIEX_FLG_N  = 4;

	// values after reset
	localparam logic [7:0]  AIEX_RST_WREG  = 8'h00;
	localparam logic [4:0]  AIEX_RST_FLAGS = 5'h00;
	localparam logic [3:0]  AIEX_RST_BANK  = 4'h0;
	localparam logic [11:0] AIEX_RST_INDEX = 12'h000;
	localparam logic [15:0] AIEX_RST_INSTR = 16'h0000;

	typedef enum logic [4:0] {
		AIEX_IDLE = 5'b00001,
		AIEX_Q1   = 5'b00010,
		AIEX_Q2   = 5'b00100,
		AIEX_Q3   = 5'b01000,
		AIEX_Q4   = 5'b10000
	} aiex_state_t;
endpackage

/* File: aiex_adder.sv */
`timescale 1ns/1ns
module aiex_adder (
	// operands
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	// result and flags
	output logic      [7:0] sum,
	output logic            carry,
	output logic            digit_carry,
	output logic            zero,
	output logic            overflow,
	output logic            negative
);
	logic [8:0] full;
	logic [4:0] low;

	always_comb begin
		full        = {1'b0, a} + {1'b0, b};
		low         = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		sum         = full[7:0];
		carry       = full[8];
		digit_carry = low[4];
		zero        = (full[7:0] == 8'h00);
		// signed overflow: like-signed operands giving an unlike-signed sum
		overflow    = (a[7] == b[7]) && (full[7] != a[7]);
		negative    = full[7];
	end
endmodule

/* File: aiex_core.sv */
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module aiex_core (
	// apb clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb request
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	// apb answer
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// execution status
	output logic             busy
);
	import aiex_pkg::*;

	logic [7:0]  data_mem [AIEX_MEM_DEPTH];

	aiex_state_t state_r, state_nxt;
	logic [15:0] instr_r, instr_nxt;
	logic [7:0]  wreg_r, wreg_nxt;
	logic [4:0]  flags_r, flags_nxt;
	logic [3:0]  bank_select_register_r, bank_select_register_nxt;
	logic [11:0] index_base_r, index_base_nxt;
	logic        ext_en_r, ext_en_nxt;
	logic [11:0] mem_addr_r, mem_addr_nxt;
	logic [11:0] eff_addr_r, eff_addr_nxt;
	logic [7:0]  operand_r, operand_nxt;
	logic [7:0]  result_r, result_nxt;
	logic [4:0]  res_flags_r, res_flags_nxt;
	logic        illegal_r, illegal_nxt;
	logic        busy_r, busy_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;

	logic        mem_we;
	logic [11:0] mem_wa;
	logic [7:0]  mem_wd;
	logic        wr_acc;
	logic [7:0]  alu_sum;
	logic        alu_c, alu_dc, alu_z, alu_ov, alu_n;

	function automatic logic is_add_immediate_to_accumulator(input logic [15:0] ins);
		is_add_immediate_to_accumulator = (ins[15:8] == AIEX_OPC_LIT);
	endfunction

	function automatic logic is_add_accumulator_to_file(input logic [15:0] ins);
		is_add_accumulator_to_file = (ins[15:10] == AIEX_OPC_FILE);
	endfunction

	function automatic logic [11:0] resolve_addr(input logic [7:0] f, input logic bank_bit,
	                                              input logic ext, input logic [3:0] bank,
	                                              input logic [11:0] base);
		if (bank_bit) begin
			resolve_addr = {bank, f};
		end else if (ext && (f <= AIEX_ILO_MAX)) begin
			resolve_addr = base + {4'h0, f};
		end else if (f < AIEX_ACC_SPLIT) begin
			resolve_addr = {AIEX_ACC_LO_BANK, f};
		end else begin
			resolve_addr = {AIEX_ACC_HI_BANK, f};
		end
	endfunction

	function automatic logic is_state_reg(input logic [7:0] a);
		is_state_reg = (a == AIEX_OFF_CTRL) || (a == AIEX_OFF_INSTR) || (a == AIEX_OFF_WREG) ||
		               (a == AIEX_OFF_FLAGS) || (a == AIEX_OFF_BANK) || (a == AIEX_OFF_INDEX_BASE) ||
		               (a == AIEX_OFF_MEM_DATA);
	endfunction

	aiex_adder u_adder (
		.a           (wreg_r),
		.b           (operand_r),
		.sum         (alu_sum),
		.carry       (alu_c),
		.digit_carry (alu_dc),
		.zero        (alu_z),
		.overflow    (alu_ov),
		.negative    (alu_n)
	);

	assign wr_acc = psel && penable && pready_r && pwrite && !pslverr_r;

	// apb answer: pready rises in the first access cycle, so every transfer has no wait state
	always_comb begin
		pready_nxt  = psel && !penable && !pready_r;
		pslverr_nxt = 1'b0;
		prdata_nxt  = 32'h0000_0000;
		if (psel && !penable && !pready_r) begin
			// writes that would race the running instruction are refused
			if (pwrite && busy_r && is_state_reg(paddr)) begin
				pslverr_nxt = 1'b1;
			end
			case (paddr)
				AIEX_OFF_CTRL:       prdata_nxt = {31'h0, ext_en_r};
				AIEX_OFF_INSTR:      prdata_nxt = {16'h0, instr_r};
				AIEX_OFF_WREG:       prdata_nxt = {24'h0, wreg_r};
				AIEX_OFF_FLAGS:      prdata_nxt = {27'h0, flags_r};
				AIEX_OFF_BANK:       prdata_nxt = {28'h0, bank_select_register_r};
				AIEX_OFF_INDEX_BASE: prdata_nxt = {20'h0, index_base_r};
				AIEX_OFF_MEM_ADDR:   prdata_nxt = {20'h0, mem_addr_r};
				AIEX_OFF_MEM_DATA:   prdata_nxt = {24'h0, data_mem[mem_addr_r]};
				AIEX_OFF_EXEC_STAT:  prdata_nxt = {4'h0, eff_addr_r, 14'h0, illegal_r, busy_r};
				default:             pslverr_nxt = 1'b1;
			endcase
		end
	end

	always_comb begin
		state_nxt                = state_r;
		instr_nxt                = instr_r;
		wreg_nxt                 = wreg_r;
		flags_nxt                = flags_r;
		bank_select_register_nxt = bank_select_register_r;
		index_base_nxt           = index_base_r;
		ext_en_nxt               = ext_en_r;
		mem_addr_nxt             = mem_addr_r;
		eff_addr_nxt             = eff_addr_r;
		operand_nxt              = operand_r;
		result_nxt               = result_r;
		res_flags_nxt            = res_flags_r;
		illegal_nxt              = illegal_r;
		mem_we                   = 1'b0;
		mem_wa                   = mem_addr_r;
		mem_wd                   = pwdata[7:0];
		if (wr_acc) begin
			case (paddr)
				AIEX_OFF_CTRL:       ext_en_nxt = pwdata[0];
				AIEX_OFF_WREG:       wreg_nxt = pwdata[7:0];
				AIEX_OFF_FLAGS:      flags_nxt = pwdata[4:0];
				AIEX_OFF_BANK:       bank_select_register_nxt = pwdata[3:0];
				AIEX_OFF_INDEX_BASE: index_base_nxt = pwdata[11:0];
				AIEX_OFF_MEM_ADDR:   mem_addr_nxt = pwdata[11:0];
				AIEX_OFF_MEM_DATA:   mem_we = 1'b1;
				AIEX_OFF_INSTR: begin
					instr_nxt   = pwdata[15:0];
					illegal_nxt = 1'b0;
					state_nxt   = AIEX_Q1;
				end
				default: ;
			endcase
		end
		// one instruction cycle: decode, read, process, write
		case (state_r)
			AIEX_IDLE: ;
			AIEX_Q1: begin
				eff_addr_nxt = resolve_addr(instr_r[7:0], instr_r[AIEX_POS_BANKSEL], ext_en_r,
				                            bank_select_register_r, index_base_r);
				if (is_add_immediate_to_accumulator(instr_r) || is_add_accumulator_to_file(instr_r)) begin
					state_nxt = AIEX_Q2;
				end else begin
					illegal_nxt = 1'b1;
					state_nxt   = AIEX_IDLE;
				end
			end
			AIEX_Q2: begin
				if (is_add_immediate_to_accumulator(instr_r)) begin
					operand_nxt = instr_r[7:0];
				end else begin
					operand_nxt = data_mem[eff_addr_r];
				end
				state_nxt = AIEX_Q3;
			end
			AIEX_Q3: begin
				result_nxt = alu_sum;
				res_flags_nxt[AIEX_FLG_C]  = alu_c;
				res_flags_nxt[AIEX_FLG_DC] = alu_dc;
				res_flags_nxt[AIEX_FLG_Z]  = alu_z;
				res_flags_nxt[AIEX_FLG_OV] = alu_ov;
				res_flags_nxt[AIEX_FLG_N]  = alu_n;
				state_nxt = AIEX_Q4;
			end
			AIEX_Q4: begin
				flags_nxt = res_flags_r;
				if (is_add_accumulator_to_file(instr_r) && instr_r[AIEX_POS_DEST]) begin
					mem_we = 1'b1;
					mem_wa = eff_addr_r;
					mem_wd = result_r;
				end else begin
					wreg_nxt = result_r;
				end
				state_nxt = AIEX_IDLE;
			end
			default: state_nxt = AIEX_IDLE;
		endcase
		busy_nxt = (state_nxt != AIEX_IDLE);
	end

	// memory has no reset; software loads it through the window registers
	always_ff @(posedge pclk) begin
		if (mem_we) begin
			data_mem[mem_wa] <= mem_wd;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r                <= AIEX_IDLE;
			instr_r                <= AIEX_RST_INSTR;
			wreg_r                 <= AIEX_RST_WREG;
			flags_r                <= AIEX_RST_FLAGS;
			bank_select_register_r <= AIEX_RST_BANK;
			index_base_r           <= AIEX_RST_INDEX;
			ext_en_r               <= 1'b0;
			mem_addr_r             <= 12'h000;
			eff_addr_r             <= 12'h000;
			operand_r              <= 8'h00;
			result_r               <= 8'h00;
			res_flags_r            <= 5'h00;
			illegal_r              <= 1'b0;
			busy_r                 <= 1'b0;
			prdata_r               <= 32'h0000_0000;
			pready_r               <= 1'b0;
			pslverr_r              <= 1'b0;
		end else begin
			state_r                <= state_nxt;
			instr_r                <= instr_nxt;
			wreg_r                 <= wreg_nxt;
			flags_r                <= flags_nxt;
			bank_select_register_r <= bank_select_register_nxt;
			index_base_r           <= index_base_nxt;
			ext_en_r               <= ext_en_nxt;
			mem_addr_r             <= mem_addr_nxt;
			eff_addr_r             <= eff_addr_nxt;
			operand_r              <= operand_nxt;
			result_r               <= result_nxt;
			res_flags_r            <= res_flags_nxt;
			illegal_r              <= illegal_nxt;
			busy_r                 <= busy_nxt;
			prdata_r               <= prdata_nxt;
			pready_r               <= pready_nxt;
			pslverr_r              <= pslverr_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign busy    = busy_r;
endmodule

/* File: aiex_core_properties.sv */
`timescale 1ns/1ns
module aiex_chk (
	// apb request
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	// answer and status
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        busy
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic go;
	// an accepted instruction write; a refused one must not start work
	assign go = psel && penable && pready && pwrite && paddr == 8'h04 && !busy;
	lit_len_a: assert property (go && pwdata[15:8] == 8'h0F |=> busy [*4] ##1 !busy)
		else $error("literal add not four cycles");
	file_len_a: assert property (go && pwdata[15:10] == 6'h09 |=> busy [*4] ##1 !busy)
		else $error("file add not four cycles");
	bad_op_a: assert property (go && pwdata[15:8] != 8'h0F && pwdata[15:10] != 6'h09 |=> busy ##1 !busy)
		else $error("illegal opcode busy length wrong");
	busy_cause_a: assert property ($rose(busy) |-> $past(go))
		else $error("busy rose without instruction");
	rdy_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready not a single pulse");
	err_rdy_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	rd_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	hole_err_a: assert property (psel && !penable && paddr > 8'h20 |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
endmodule

bind aiex_core aiex_chk aiex_chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .busy);

/* File: test_add_instruction_execute.sv */
`timescale 1ns/1ns
module test_add_instruction_execute;
	import aiex_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy;
	logic [31:0] rd;
	logic        er;
	int          err_total = 0;
	int          n_compared = 0;
	// w, k, sum, flags
	logic [31:0] lit [4] = '{32'h10152500, 32'h7F01801A, 32'hFF010007, 32'h8080000D};
	// ctrl, bank, index base, instruction, effective address
	logic [47:0] ea [6] = '{48'h00000241_0010, 48'h00000248_0F80, 48'h10200245_F25F, 48'h10200246_0F60,
		48'h15200251_0510, 48'h10FF0242_0010};
	always #5 pclk = ~pclk;
	aiex_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .busy);
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one transfer; the extra idle edge keeps psel from being set twice in one step
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			err_total++;
			tally_and_finish();
		end
		@(posedge pclk);
	endtask
	task automatic idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20) begin
			err_total++;
			tally_and_finish();
		end
	endtask
	task automatic run(input logic [15:0] op);
		xfer(AIEX_OFF_INSTR, 1'b1, {16'h0, op});
		idle();
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		chk(nm, rd, e);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk("wreg", AIEX_OFF_WREG, 32'h0);
		rchk("flags", AIEX_OFF_FLAGS, 32'h0);
		foreach (lit[i]) begin
			xfer(AIEX_OFF_WREG, 1'b1, {24'h0, lit[i][31:24]});
			run({8'h0F, lit[i][23:16]});
			rchk("lit sum", AIEX_OFF_WREG, {24'h0, lit[i][15:8]});
			rchk("lit flags", AIEX_OFF_FLAGS, {24'h0, lit[i][7:0]});
		end
		xfer(AIEX_OFF_BANK, 1'b1, 32'h3);
		xfer(AIEX_OFF_MEM_ADDR, 1'b1, 32'h345);
		xfer(AIEX_OFF_MEM_DATA, 1'b1, 32'hC2);
		xfer(AIEX_OFF_WREG, 1'b1, 32'h17);
		run(16'h2545);
		rchk("file to w", AIEX_OFF_WREG, 32'hD9);
		rchk("file kept", AIEX_OFF_MEM_DATA, 32'hC2);
		rchk("file flags", AIEX_OFF_FLAGS, 32'h10);
		run(16'h2745);
		rchk("file to mem", AIEX_OFF_MEM_DATA, 32'h9B);
		rchk("w kept", AIEX_OFF_WREG, 32'hD9);
		rchk("carry flags", AIEX_OFF_FLAGS, 32'h11);
		xfer(AIEX_OFF_INSTR, 1'b1, 32'h0F01);
		xfer(AIEX_OFF_WREG, 1'b1, 32'h55);
		chk("busy refusal", {31'h0, er}, 32'h1);
		idle();
		rchk("w after refusal", AIEX_OFF_WREG, 32'hDA);
		xfer(8'h24, 1'b0, 32'h0);
		chk("hole err", {31'h0, er}, 32'h1);
		chk("hole data", rd, 32'h0);
		xfer(AIEX_OFF_EXEC_STAT, 1'b1, 32'hFFFFFFFF);
		chk("status ro", {31'h0, er}, 32'h0);
		run(16'h1234);
		// decode still resolves the address field of an unknown word: access bank, 0x34
		rchk("illegal", AIEX_OFF_EXEC_STAT, {4'h0, 12'h034, 16'h2});
		rchk("w untouched", AIEX_OFF_WREG, 32'hDA);
		// memory here is not loaded, so only the resolved address is judged
		foreach (ea[i]) begin
			xfer(AIEX_OFF_CTRL, 1'b1, {28'h0, ea[i][47:44]});
			xfer(AIEX_OFF_BANK, 1'b1, {28'h0, ea[i][43:40]});
			xfer(AIEX_OFF_INDEX_BASE, 1'b1, {20'h0, ea[i][39:28]});
			run(ea[i][27:12]);
			xfer(AIEX_OFF_EXEC_STAT, 1'b0, 32'h0);
			chk("eff addr", {20'h0, rd[27:16]}, {20'h0, ea[i][11:0]});
		end
		tally_and_finish();
	end
endmodule
